// ===== verilog/irq_unit.sv
// Six-source, four-level interrupt controller for an 8-bit core.
// Assumes the core clock drives I_CLK and source requests are synchronous.
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/1ns
module irq_unit
  import irq_unit_pkg::*;
(
  // Clock and reset
  input wire logic I_CLK,
  input wire logic I_RESET,
  // Register port
  input wire logic [7:0] I_ADDR,
  input wire logic [7:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  output logic [7:0] O_RDATA,
  // Interrupt sources, active-high one-cycle or level requests
  input wire logic I_EXT_REQUEST0_PIN,
  input wire logic I_EXT_REQUEST1_PIN,
  input wire logic I_TIMER0_OVF,
  input wire logic I_TIMER1_OVF,
  input wire logic I_TIMER2_OVF,
  input wire logic I_SERIAL_IRQ,
  // CPU core interface
  output logic O_IRQ_REQ,
  output logic [2:0] O_IRQ_VECTOR,
  output logic [1:0] O_IRQ_LEVEL,
  input wire logic I_IRQ_ACK,
  input wire logic I_IRQ_RET,
  // Summary interrupt for the status/mask logic
  output logic O_IRQ
);
  // All module state in one struct
  typedef struct packed {
    logic [7:0] irq_enable_reg;
    logic [5:0] irq_prio_low_reg;
    logic [5:0] irq_prio_high_reg;
    logic [5:0] status;
    logic [5:0] mask;
    logic [7:0] rdata;
    irq_req_t req;
  } unit_state_t;
  unit_state_t q, d;

  bus_req_t bus;
  logic [NUM_SRC-1:0] raw;
  logic [NUM_SRC-1:0] pend;
  logic [NUM_SRC-1:0] gated;
  logic [NUM_SRC-1:0] eligible;
  logic [NUM_LVL-1:0] active;
  irq_req_t win;
  logic [1:0] cur_level;
  logic any_active;
  logic take_ack;

  assign bus = '{addr: I_ADDR, wdata: I_WDATA, wr: I_WR, rd: I_RD};

  // Source vector in enable-register bit order
  always_comb begin
    raw = '0;
    raw[BIT_EXT0] = I_EXT_REQUEST0_PIN;
    raw[BIT_TIMER0] = I_TIMER0_OVF;
    raw[BIT_EXT1] = I_EXT_REQUEST1_PIN;
    raw[BIT_TIMER1] = I_TIMER1_OVF;
    raw[BIT_SERIAL] = I_SERIAL_IRQ;
    raw[BIT_TIMER2] = I_TIMER2_OVF;
  end

  // Pending sources: sticky status holds short pulses until serviced
  assign pend = raw | q.status;

  // Per-source and global gating
  assign gated = pend & q.irq_enable_reg[NUM_SRC-1:0]
    & {NUM_SRC{q.irq_enable_reg[BIT_GLOBAL_GATE]}};

  // Current handler level from the tracker
  always_comb begin
    cur_level = 2'h0;
    for (int i = 0; i < NUM_LVL; i++) begin
      if (active[i]) cur_level = 2'(i);
    end
  end
  assign any_active = |active;

  // Only sources above the running level may preempt it
  genvar g;
  generate
    for (g = 0; g < NUM_SRC; g++) begin : g_elig
      logic [1:0] lvl;
      assign lvl = {q.irq_prio_high_reg[g], q.irq_prio_low_reg[g]};
      assign eligible[g] = gated[g]
        && (!any_active || lvl > cur_level)
        && !active[NUM_LVL-1];
    end
  endgenerate

  // Level and poll-order selection
  irq_prio_arbiter #(
    .N(NUM_SRC)
  ) u_arb (
    .i_req(eligible),
    .i_prio_high(q.irq_prio_high_reg),
    .i_prio_low(q.irq_prio_low_reg),
    .o_win(win)
  );

  // Acknowledge only counts while a request is offered
  assign take_ack = I_IRQ_ACK && q.req.valid;

  // Nesting tracker
  irq_level_stack u_stk (
    .i_clk(I_CLK),
    .i_reset(I_RESET),
    .i_ack(take_ack),
    .i_ack_level(q.req.level),
    .i_ret(I_IRQ_RET),
    .o_active(active)
  );

  // Next-state logic: registers, status, read data and request
  always_comb begin
    d = q;
    d.rdata = RSVD_READ;
    // Status: set by events, write-one-to-clear, set wins over clear
    if (bus.wr && bus.addr == ADDR_IRQ_STATUS) begin
      d.status = q.status & ~bus.wdata[NUM_SRC-1:0];
    end
    if (take_ack) begin
      // Serviced source leaves the pending set
      d.status[q.req.src] = 1'b0;
    end
    d.status = d.status | raw;
    // Register writes
    if (bus.wr) begin
      if (bus.addr == ADDR_IRQ_ENABLE) begin
        d.irq_enable_reg = bus.wdata & 8'hbf;
      end else if (bus.addr == ADDR_PRIO_LOW) begin
        d.irq_prio_low_reg = bus.wdata[5:0];
      end else if (bus.addr == ADDR_PRIO_HIGH) begin
        d.irq_prio_high_reg = bus.wdata[5:0];
      end else if (bus.addr == ADDR_IRQ_MASK) begin
        d.mask = bus.wdata[5:0];
      end
    end
    // Register reads, data valid the next cycle
    if (bus.rd) begin
      if (bus.addr == ADDR_IRQ_ENABLE) begin
        d.rdata = q.irq_enable_reg;
      end else if (bus.addr == ADDR_PRIO_LOW) begin
        d.rdata = {2'h0, q.irq_prio_low_reg};
      end else if (bus.addr == ADDR_PRIO_HIGH) begin
        d.rdata = {2'h0, q.irq_prio_high_reg};
      end else if (bus.addr == ADDR_IRQ_STATUS) begin
        d.rdata = {2'h0, q.status};
      end else if (bus.addr == ADDR_IRQ_MASK) begin
        d.rdata = {2'h0, q.mask};
      end else if (bus.addr == ADDR_IRQ_ACTIVE) begin
        d.rdata = {4'h0, active};
      end else begin
        d.rdata = RSVD_READ;
      end
    end
    // Offered request is re-evaluated every cycle; cleared on acknowledge
    d.req = take_ack ? '0 : win;
  end

  // State register; the priority registers have no documented reset,
  // cleared anyway so simulation starts from a known level
  always_ff @(posedge I_CLK) begin
    if (I_RESET) begin
      q.irq_enable_reg <= RST_IRQ_ENABLE;
      q.irq_prio_low_reg <= RST_PRIO;
      q.irq_prio_high_reg <= RST_PRIO;
      q.status <= RST_STATUS;
      q.mask <= RST_STATUS;
      q.rdata <= RSVD_READ;
      q.req <= '0;
    end else begin
      q <= d;
    end
  end

  // Outputs
  assign O_RDATA = q.rdata;
  assign O_IRQ_REQ = q.req.valid;
  assign O_IRQ_VECTOR = q.req.src;
  assign O_IRQ_LEVEL = q.req.level;
  assign O_IRQ = |(q.status & q.mask);
endmodule

// ===== verilog/irq_unit_pkg.sv
// Package for the six-source priority interrupt unit.
// Assumes a single 50 MHz core clock and special-register addressing.
package irq_unit_pkg;
  localparam int NUM_SRC = 6;
  localparam int NUM_LVL = 4;
  // Special-register addresses
  localparam logic [7:0] ADDR_IRQ_ENABLE = 8'ha8;
  localparam logic [7:0] ADDR_PRIO_LOW = 8'hb8;
  localparam logic [7:0] ADDR_PRIO_HIGH = 8'hb7;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'hc0;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'hc1;
  localparam logic [7:0] ADDR_IRQ_ACTIVE = 8'hc2;
  // Field positions of the enable register
  localparam int BIT_GLOBAL_GATE = 7;
  localparam int BIT_EXT0 = 0;
  localparam int BIT_TIMER0 = 1;
  localparam int BIT_EXT1 = 2;
  localparam int BIT_TIMER1 = 3;
  localparam int BIT_SERIAL = 4;
  localparam int BIT_TIMER2 = 5;
  // Reset values
  localparam logic [7:0] RST_IRQ_ENABLE = 8'h00;
  localparam logic [5:0] RST_PRIO = 6'h00;
  localparam logic [5:0] RST_STATUS = 6'h00;
  localparam logic [3:0] RST_ACTIVE = 4'h0;
  // Value returned for reserved bits and unmapped addresses
  localparam logic [7:0] RSVD_READ = 8'h00;
  // Polling order within one level: entry 0 polled first
  localparam logic [2:0] POLL_ORDER [NUM_SRC] = '{
    3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5};

  // Register bus request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } bus_req_t;

  // Request offered to the CPU core
  typedef struct packed {
    logic valid;
    logic [2:0] src;
    logic [1:0] level;
  } irq_req_t;
endpackage

// ===== verilog/irq_prio_arbiter.sv
// Priority arbiter: picks the highest level, then the first in poll order.
// Assumes requests are already gated by the enables.
`timescale 1ns/1ns
module irq_prio_arbiter
  import irq_unit_pkg::*;
#(
  parameter int N = NUM_SRC
) (
  // Requests and their levels
  input wire logic [N-1:0] i_req,
  input wire logic [N-1:0] i_prio_high,
  input wire logic [N-1:0] i_prio_low,
  // Winner
  output irq_req_t o_win
);
  // The winner's source index is three bits wide, so eight sources at most
  if (N < 1 || N > 8) begin : g_bad_n
    $error("irq_prio_arbiter supports one to eight sources");
  end

  // Higher level overrides; within a level, lower bit index wins
  always_comb begin
    logic [1:0] lvl;
    lvl = 2'h0;
    o_win = '0;
    for (int i = N - 1; i >= 0; i--) begin
      lvl = {i_prio_high[i], i_prio_low[i]};
      if (i_req[i] && (!o_win.valid || lvl >= o_win.level)) begin
        o_win.valid = 1'b1;
        o_win.src = 3'(i);
        o_win.level = lvl;
      end
    end
  end
endmodule

// ===== verilog/irq_level_stack.sv
// In-progress level tracker for nested handlers.
// Assumes acknowledge and return pulses each last one cycle.
`timescale 1ns/1ns
module irq_level_stack
  import irq_unit_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // Events from the core
  input wire logic i_ack,
  input wire logic [1:0] i_ack_level,
  input wire logic i_ret,
  // Levels in progress, one bit per level
  output logic [NUM_LVL-1:0] o_active
);
  typedef struct packed {
    logic [NUM_LVL-1:0] active;
  } stk_state_t;
  stk_state_t q, d;
  logic [NUM_LVL-1:0] top;

  // One-hot of the highest active level, which is always the most recent
  always_comb begin
    top = '0;
    for (int i = 0; i < NUM_LVL; i++) begin
      if (q.active[i]) top = NUM_LVL'(1) << i;
    end
  end

  // Release on return first, then mark a new acknowledge
  always_comb begin
    d = q;
    if (i_ret) d.active = q.active & ~top;
    if (i_ack) d.active[i_ack_level] = 1'b1;
  end

  // State register
  always_ff @(posedge i_clk) begin
    if (i_reset) q.active <= RST_ACTIVE;
    else q <= d;
  end

  assign o_active = q.active;
endmodule

// ===== verification/irq_unit_checker.sv
// Checker for the interrupt unit: register mirror and core-link timing.
// Assumes it is bound to irq_unit and sees only that module's ports.
`timescale 1ns/1ns
module irq_unit_checker (
  // Clock and reset
  input wire logic I_CLK,
  input wire logic I_RESET,
  // Register port
  input wire logic [7:0] I_ADDR,
  input wire logic [7:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  input wire logic [7:0] O_RDATA,
  // Core link
  input wire logic O_IRQ_REQ,
  input wire logic [2:0] O_IRQ_VECTOR,
  input wire logic [1:0] O_IRQ_LEVEL,
  input wire logic I_IRQ_ACK,
  input wire logic I_IRQ_RET
);
  default clocking @(posedge I_CLK); endclocking
  default disable iff (I_RESET);
  logic [7:0] en_q, en_p_q, lo_q, hi_q;
  logic top_q;
  // Mirror of written registers; en_p_q covers the one-cycle update lag
  always_ff @(posedge I_CLK) begin
    if (I_RESET) begin
      en_q <= 8'h00;
      en_p_q <= 8'h00;
      lo_q <= 8'h00;
      hi_q <= 8'h00;
      top_q <= 1'b0;
    end else begin
      en_p_q <= en_q;
      if (I_WR && I_ADDR == 8'ha8) en_q <= I_WDATA & 8'hbf;
      if (I_WR && I_ADDR == 8'hb8) lo_q <= I_WDATA & 8'h3f;
      if (I_WR && I_ADDR == 8'hb7) hi_q <= I_WDATA & 8'h3f;
      if (O_IRQ_REQ && I_IRQ_ACK && O_IRQ_LEVEL == 2'h3) top_q <= 1'b1;
      else if (I_IRQ_RET) top_q <= 1'b0;
    end
  end
  chk_read_idle: assert property (
    !$past(I_RD) |-> O_RDATA == 8'h00) else $error("read data not idle");
  chk_enable_readback: assert property (
    $past(I_RD) && $past(I_ADDR) == 8'ha8 |-> O_RDATA == en_q)
    else $error("enable readback wrong");
  chk_low_readback: assert property (
    $past(I_RD) && $past(I_ADDR) == 8'hb8 |-> O_RDATA == lo_q)
    else $error("low priority readback wrong");
  chk_high_readback: assert property (
    $past(I_RD) && $past(I_ADDR) == 8'hb7 |-> O_RDATA == hi_q)
    else $error("high priority readback wrong");
  chk_ack_drops: assert property (
    O_IRQ_REQ && I_IRQ_ACK |=> !O_IRQ_REQ) else $error("request kept");
  chk_top_blocks: assert property (
    top_q |-> !O_IRQ_REQ) else $error("request under top level");
  chk_vector_range: assert property (
    O_IRQ_REQ |-> O_IRQ_VECTOR <= 3'h5) else $error("bad vector");
  chk_gate_blocks: assert property (
    O_IRQ_REQ |-> (en_q[7] | en_p_q[7]) &&
    (en_q[O_IRQ_VECTOR] | en_p_q[O_IRQ_VECTOR]))
    else $error("disabled source offered");
  cover property (top_q);
  cover property (O_IRQ_REQ && I_IRQ_ACK && O_IRQ_LEVEL == 2'h0);
  cover property ($past(I_RD) && $past(I_ADDR) == 8'hb7);
endmodule
bind irq_unit irq_unit_checker chk_i (
  .I_CLK(I_CLK), .I_RESET(I_RESET), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA),
  .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA), .O_IRQ_REQ(O_IRQ_REQ),
  .O_IRQ_VECTOR(O_IRQ_VECTOR), .O_IRQ_LEVEL(O_IRQ_LEVEL),
  .I_IRQ_ACK(I_IRQ_ACK), .I_IRQ_RET(I_IRQ_RET));

// ===== verification/irq_core_model.sv
// Core model: accepts offered requests after a set delay.
// Assumes the controller drops its request the cycle after an accept.
`timescale 1ns/1ns
module irq_core_model (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // Offered request and test controls
  input wire logic i_req,
  input wire logic [3:0] i_delay,
  input wire logic i_ret_cmd,
  // Accept and return pulses
  output logic o_ack,
  output logic o_ret
);
  logic [3:0] wait_q;
  // Accept only a standing request, so a slow core still sees it held
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      wait_q <= 4'h0;
      o_ack <= 1'b0;
      o_ret <= 1'b0;
    end else begin
      wait_q <= (i_req && !o_ack) ? wait_q + 4'h1 : 4'h0;
      o_ack <= i_req && !o_ack && wait_q >= i_delay;
      o_ret <= i_ret_cmd;
    end
  end
endmodule

// ===== verification/irq_unit_test.sv
// Self-checking bench for the interrupt unit with a core model.
// Assumes a 50 MHz clock and a synchronous active-high reset.
`timescale 1ns/1ns
module irq_unit_test
  import irq_unit_pkg::*;
;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic rd_p = 1'b0;
  logic ret_cmd = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic [5:0] src = 6'h00;
  logic [3:0] dly = 4'h0;
  logic [7:0] rdata, e, h, l;
  logic req, ack, ret, irq;
  logic [2:0] vec;
  logic [1:0] lvl;
  logic [7:0] rq[$];
  logic [7:0] iq[$];
  logic [7:0] ops[16];
  int fails = 0;
  int cmp_count = 0;
  int cyc = 0;
  int n;
  // Clock
  always #10 clk = ~clk;
  irq_unit uut (
    .I_CLK(clk), .I_RESET(reset), .I_ADDR(addr), .I_WDATA(wdata),
    .I_WR(wr), .I_RD(rd), .O_RDATA(rdata),
    .I_EXT_REQUEST0_PIN(src[0]), .I_EXT_REQUEST1_PIN(src[2]),
    .I_TIMER0_OVF(src[1]), .I_TIMER1_OVF(src[3]), .I_TIMER2_OVF(src[5]),
    .I_SERIAL_IRQ(src[4]), .O_IRQ_REQ(req), .O_IRQ_VECTOR(vec),
    .O_IRQ_LEVEL(lvl), .I_IRQ_ACK(ack), .I_IRQ_RET(ret), .O_IRQ(irq));
  irq_core_model core (
    .i_clk(clk), .i_reset(reset), .i_req(req), .i_delay(dly),
    .i_ret_cmd(ret_cmd), .o_ack(ack), .o_ret(ret));
  task automatic chk(input string s, input logic [7:0] v, x);
    cmp_count++;
    if (v !== x) begin
      fails++;
      $display("FAIL %s exp %h seen %h", s, x, v);
    end
  endtask
  task automatic print_verdict;
    if (fails == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // One-cycle register strobe, write when w is set
  task automatic bus(input logic w, input logic [7:0] a, d);
    @(posedge clk);
    wr <= w;
    rd <= !w;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task automatic rdx(input logic [7:0] a, x);
    rq.push_back(x);
    bus(1'b0, a, 8'h00);
  endtask
  task automatic fire(input logic [5:0] m);
    @(posedge clk);
    src <= m;
    @(posedge clk);
    src <= 6'h00;
  endtask
  // Bounded by the cycle ceiling below
  task automatic wait_ack;
    do @(posedge clk); while (!(ack && req));
  endtask
  task automatic rtn;
    @(posedge clk);
    ret_cmd <= 1'b1;
    @(posedge clk);
    ret_cmd <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  // Results are matched to the oldest note; extra results meet an unknown
  always @(posedge clk) begin
    rd_p <= rd;
    if (rd_p)
      chk("rdata", rdata, rq.size() ? rq.pop_front() : 8'hxx);
    if (ack && req)
      chk("irq", {3'h0, lvl, vec}, iq.size() ? iq.pop_front() : 8'hxx);
    cyc++;
    if (cyc > 20000) begin
      fails++;
      print_verdict();
    end
  end
  // Main sequence
  initial begin
    void'($urandom(32'h84c3d494));
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    rdx(ADDR_IRQ_ENABLE, RST_IRQ_ENABLE);
    rdx(ADDR_PRIO_LOW, 8'h00);
    rdx(8'h10, RSVD_READ);
    bus(1'b1, ADDR_IRQ_ENABLE, 8'h3f);
    fire(6'h3f);
    repeat (10) @(posedge clk);
    for (int r = 0; r < 4; r++) begin
      bus(1'b1, ADDR_IRQ_STATUS, 8'h3f);
      e = 8'h80 | (8'($urandom) & 8'h3f);
      h = 8'($urandom) & 8'h3f;
      l = 8'($urandom) & 8'h3f;
      dly <= 4'($urandom % 4);
      bus(1'b1, ADDR_PRIO_HIGH, h);
      bus(1'b1, ADDR_PRIO_LOW, l);
      bus(1'b1, ADDR_IRQ_ENABLE, e);
      rdx(ADDR_PRIO_HIGH, h);
      for (int v = 3; v >= 0; v--)
        for (int i = 0; i < 6; i++)
          if (e[i] && {h[i], l[i]} == 2'(v))
            iq.push_back({3'h0, 2'(v), 3'(i)});
      n = iq.size();
      fire(6'h3f);
      repeat (n) begin
        wait_ack();
        rtn();
      end
    end
    // Drop pending bits of sources the last random pass left disabled
    bus(1'b1, ADDR_IRQ_STATUS, 8'h3f);
    bus(1'b1, ADDR_PRIO_HIGH, 8'h06);
    bus(1'b1, ADDR_PRIO_LOW, 8'h0d);
    bus(1'b1, ADDR_IRQ_ENABLE, 8'h8f);
    iq = '{8'h08, 8'h11, 8'h1a, 8'h11, 8'h0b};
    // 8'hcc reads the in-progress levels while levels 1, 2 and 3 nest
    ops = '{8'h01, 8'haa, 8'h08, 8'h02, 8'haa, 8'h04, 8'haa, 8'hcc,
      8'h02, 8'hee, 8'hee, 8'haa, 8'hee, 8'hee, 8'haa, 8'hee};
    foreach (ops[i]) begin
      if (ops[i] == 8'haa) wait_ack();
      else if (ops[i] == 8'hee) rtn();
      else if (ops[i] == 8'hcc) rdx(ADDR_IRQ_ACTIVE, 8'h0e);
      else fire(ops[i][5:0]);
    end
    bus(1'b1, ADDR_IRQ_ENABLE, 8'h00);
    fire(6'h10);
    rdx(ADDR_IRQ_STATUS, 8'h10);
    chk("irq_out", {7'h0, irq}, 8'h00);
    bus(1'b1, ADDR_IRQ_MASK, 8'h10);
    @(posedge clk);
    chk("irq_out", {7'h0, irq}, 8'h01);
    bus(1'b1, ADDR_IRQ_STATUS, 8'h10);
    @(posedge clk);
    chk("irq_out", {7'h0, irq}, 8'h00);
    repeat (5) @(posedge clk);
    chk("notes", 8'(rq.size() + iq.size()), 8'h00);
    print_verdict();
  end
endmodule
